// [hdl/mcu_config_upper.v]
`timescale 1ns/100ps
`default_nettype none
`include "mcu_consts.vh"

// Overview of operation
// - settling select picks 650 or 1300 ms
// - enable low keeps port off, pulse out
// - enable high turns port on, clock out
// - writing one to bit 7 starts reset
// - phase A current pairs with A, B, C
// - phase B current pairs with B, C, A
// - phase C current pairs with C, A, B
// - code 11 acts like code 00
// - select low gives neutral current rms
// - select high gives phase sum rms
// - bit 15 is reserved, no effect
// - register sits at index 0xE618
module mcu_config_upper #(
  parameter DW            = 24,
  parameter LPF_SHORT_CYC = `MCU_LPF_SHORT_CYC,
  parameter LPF_LONG_CYC  = `MCU_LPF_LONG_CYC,
  parameter SWR_CYC       = `MCU_SWR_CYC
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [19:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output wire          pslverr,
  output reg  [31:0]   prdata,
  // Phase samples from the datapath
  input  wire [DW-1:0] voltage_a,
  input  wire [DW-1:0] voltage_b,
  input  wire [DW-1:0] voltage_c,
  output reg  [DW-1:0] volt_for_current_a,
  output reg  [DW-1:0] volt_for_current_b,
  output reg  [DW-1:0] volt_for_current_c,
  // Neutral rms sources
  input  wire [31:0]   neutral_current_rms,
  input  wire [31:0]   phase_current_sum_rms,
  output reg  [31:0]   neutral_rms_result,
  // Shared pulse and clock pin
  input  wire          third_pulse_output,
  input  wire          capture_port_clock,
  output reg           shared_pin_out,
  output reg           high_speed_capture_port_on,
  // Filter settling
  output reg  [31:0]   filter_settle_cycles,
  output reg           filter_settling,
  // Software reset
  output reg           soft_reset_active
);

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------

  // Rotation picks own, next or previous phase; code 11 falls to own.
  function [DW-1:0] vpick;
    input [1:0]    code;
    input [DW-1:0] own;
    input [DW-1:0] nxt;
    input [DW-1:0] prv;
    begin
      if (code == `MCU_VSEL_NEXT)
        vpick = nxt;
      else if (code == `MCU_VSEL_PREV)
        vpick = prv;
      else
        vpick = own;
    end
  endfunction

  // Settling length in clock cycles for the chosen filter setting.
  function [31:0] settle_len;
    input sel;
    begin
      if (sel)
        settle_len = LPF_LONG_CYC[31:0];
      else
        settle_len = LPF_SHORT_CYC[31:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------

  reg        lpf_sel_q;
  reg        cap_en_q;
  reg [1:0]  vsel_a_q;
  reg [1:0]  vsel_b_q;
  reg [1:0]  vsel_c_q;
  reg        nsel_q;
  reg [7:0]  swr_cnt_q;
  reg [31:0] settle_cnt_q;
  reg        lpf_prev_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  wire acc       = psel & penable;
  wire hit_cfg   = (paddr == `MCU_CFG_ADDR);
  wire hit_nrms  = (paddr == `MCU_NRMS_ADDR);
  wire wr_cfg    = acc & pwrite & hit_cfg & ~soft_reset_active;
  wire swr_start = wr_cfg & pwdata[`MCU_SWR_BIT];
  wire swr_last  = soft_reset_active && (swr_cnt_q == 8'h01);

  // The slave always answers in the access cycle, so no wait states.
  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_cfg | hit_nrms);

  // ----------------------------------------------------------------
  // Field registers
  // ----------------------------------------------------------------

  // Writes are ignored while a soft reset runs, so the clear at its
  // last cycle cannot be undone by a late bus write.
  // bit 15 has no storage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lpf_sel_q <= 1'b0;
    else if (swr_last)
      lpf_sel_q <= 1'b0;
    else if (wr_cfg)
      lpf_sel_q <= pwdata[`MCU_LPF_BIT];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_en_q <= 1'b0;
    else if (swr_last)
      cap_en_q <= 1'b0;
    else if (wr_cfg)
      cap_en_q <= pwdata[`MCU_CAP_BIT];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vsel_a_q <= `MCU_VSEL_RESET;
    else if (swr_last)
      vsel_a_q <= `MCU_VSEL_RESET;
    else if (wr_cfg)
      vsel_a_q <= pwdata[`MCU_VSA_LSB+1:`MCU_VSA_LSB];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vsel_b_q <= `MCU_VSEL_RESET;
    else if (swr_last)
      vsel_b_q <= `MCU_VSEL_RESET;
    else if (wr_cfg)
      vsel_b_q <= pwdata[`MCU_VSB_LSB+1:`MCU_VSB_LSB];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vsel_c_q <= `MCU_VSEL_RESET;
    else if (swr_last)
      vsel_c_q <= `MCU_VSEL_RESET;
    else if (wr_cfg)
      vsel_c_q <= pwdata[`MCU_VSC_LSB+1:`MCU_VSC_LSB];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nsel_q <= 1'b0;
    else if (swr_last)
      nsel_q <= 1'b0;
    else if (wr_cfg)
      nsel_q <= pwdata[`MCU_NSEL_BIT];
  end

  // ----------------------------------------------------------------
  // Software reset
  // ----------------------------------------------------------------

  // Writes are refused while the reset runs so it cannot be retriggered.
  // Only this block's fields are cleared; other logic resets elsewhere.
  // writing one starts reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_reset_active <= 1'b0;
    else if (swr_start)
      soft_reset_active <= 1'b1;
    else if (swr_last)
      soft_reset_active <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      swr_cnt_q <= 8'h00;
    else if (swr_start)
      swr_cnt_q <= SWR_CYC[7:0];
    else if (soft_reset_active)
      swr_cnt_q <= swr_cnt_q - 8'h01;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  always @*
  begin
    prdata = 32'h00000000;
    if (hit_cfg)
    begin
      prdata[`MCU_LPF_BIT]                 = lpf_sel_q;
      prdata[`MCU_CAP_BIT]                 = cap_en_q;
      prdata[`MCU_SWR_BIT]                 = soft_reset_active;
      prdata[`MCU_VSA_LSB+1:`MCU_VSA_LSB]  = vsel_a_q;
      prdata[`MCU_VSB_LSB+1:`MCU_VSB_LSB]  = vsel_b_q;
      prdata[`MCU_VSC_LSB+1:`MCU_VSC_LSB]  = vsel_c_q;
      prdata[`MCU_NSEL_BIT]                = nsel_q;
    end
    else if (hit_nrms)
      prdata = neutral_rms_result;
  end

  // ----------------------------------------------------------------
  // Datapath steering
  // ----------------------------------------------------------------

  // Steering is registered, so every output follows its setting one cycle late.
  // phase A pairing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      volt_for_current_a <= {DW{1'b0}};
    else
      volt_for_current_a <= vpick(vsel_a_q, voltage_a, voltage_b, voltage_c);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      volt_for_current_b <= {DW{1'b0}};
    else
      volt_for_current_b <= vpick(vsel_b_q, voltage_b, voltage_c, voltage_a);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      volt_for_current_c <= {DW{1'b0}};
    else
      volt_for_current_c <= vpick(vsel_c_q, voltage_c, voltage_a, voltage_b);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      neutral_rms_result <= 32'h00000000;
    else
      neutral_rms_result <= nsel_q ? phase_current_sum_rms : neutral_current_rms;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_pin_out             <= 1'b0;
      high_speed_capture_port_on <= 1'b0;
    end
    else
    begin
      high_speed_capture_port_on <= cap_en_q;
      shared_pin_out             <= cap_en_q ? capture_port_clock : third_pulse_output;
    end
  end

  // ----------------------------------------------------------------
  // Filter settling timer
  // ----------------------------------------------------------------

  // A change of setting restarts the wait, since the filter output is
  // not trustworthy until the new settling time has passed.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lpf_prev_q           <= 1'b0;
      filter_settle_cycles <= 32'h00000000;
    end
    else
    begin
      lpf_prev_q           <= lpf_sel_q;
      filter_settle_cycles <= settle_len(lpf_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_cnt_q <= 32'h00000000;
    else if (lpf_prev_q != lpf_sel_q)
      settle_cnt_q <= 32'h00000000;
    else if (filter_settling)
      settle_cnt_q <= settle_cnt_q + 32'h00000001;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filter_settling <= 1'b1;
    else if (lpf_prev_q != lpf_sel_q)
      filter_settling <= 1'b1;
    else if (filter_settling)
      filter_settling <= (settle_cnt_q + 32'h00000001) < settle_len(lpf_sel_q);
  end

endmodule

`default_nettype wire

// [hdl/mcu_consts.vh]
`ifndef MCU_CONSTS_VH
`define MCU_CONSTS_VH

// Register indices as printed; the byte address is four times the index.
`define MCU_CFG_INDEX      20'hE618
`define MCU_NRMS_INDEX     20'h43C9
`define MCU_CFG_ADDR       20'h39860
`define MCU_NRMS_ADDR      20'h10F24

// Field positions of the configuration register.
`define MCU_LPF_BIT        5
`define MCU_CAP_BIT        6
`define MCU_SWR_BIT        7
`define MCU_VSA_LSB        8
`define MCU_VSB_LSB        10
`define MCU_VSC_LSB        12
`define MCU_NSEL_BIT       14
`define MCU_RSV_BIT        15

// Reset values.
`define MCU_CFG_RESET      11'h000
`define MCU_VSEL_RESET     2'h0

// Voltage selector codes.
`define MCU_VSEL_OWN       2'h0
`define MCU_VSEL_NEXT      2'h1
`define MCU_VSEL_PREV      2'h2

// Timing.
`define MCU_CLK_KHZ        40000
`define MCU_LPF_SHORT_MS   650
`define MCU_LPF_LONG_MS    1300
`define MCU_LPF_SHORT_CYC  (`MCU_LPF_SHORT_MS * `MCU_CLK_KHZ)
`define MCU_LPF_LONG_CYC   (`MCU_LPF_LONG_MS * `MCU_CLK_KHZ)
`define MCU_SWR_CYC        16

`endif

// [testbench/mcu_config_upper_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mcu_consts.vh"
module mcu_config_upper_chk #(
  parameter DW            = 24,
  parameter LPF_SHORT_CYC = 20,
  parameter LPF_LONG_CYC  = 40,
  parameter SWR_CYC       = 16
) (
  input wire logic          pclk, presetn, psel, penable, pwrite, pslverr,
  input wire logic [19:0]   paddr,
  input wire logic [31:0]   pwdata, prdata,
  input wire logic [DW-1:0] voltage_a, voltage_b, voltage_c,
  input wire logic [DW-1:0] volt_for_current_a, volt_for_current_b, volt_for_current_c,
  input wire logic [31:0]   neutral_current_rms, phase_current_sum_rms, neutral_rms_result,
  input wire logic          third_pulse_output, capture_port_clock, shared_pin_out,
  input wire logic          high_speed_capture_port_on, soft_reset_active,
  input wire logic [31:0]   filter_settle_cycles
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_cfg;
  assign rd_cfg = psel && penable && !pwrite && paddr == `MCU_CFG_ADDR;
  function automatic logic [DW-1:0] pick(input logic [1:0] c, input logic [DW-1:0] o, n, p);
    return c == 2'h1 ? n : (c == 2'h2 ? p : o);
  endfunction
  sequence s_swr;
    psel && penable && pwrite && paddr == `MCU_CFG_ADDR && pwdata[7] && !soft_reset_active;
  endsequence
  property p_err;
    psel && penable && paddr != `MCU_CFG_ADDR && paddr != `MCU_NRMS_ADDR |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("Unmapped access accepted.");
  property p_rsv;
    rd_cfg |-> prdata[31:15] == 17'h0 && prdata[4:0] == 5'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Unused bits read nonzero.");
  property p_lpf;
    rd_cfg |=> filter_settle_cycles == ($past(prdata[5]) ? LPF_LONG_CYC : LPF_SHORT_CYC);
  endproperty
  a_lpf: assert property (p_lpf) else $error("Settling length wrong.");
  property p_cap;
    rd_cfg |=> high_speed_capture_port_on == $past(prdata[6]);
  endproperty
  a_cap: assert property (p_cap) else $error("Capture port state wrong.");
  property p_pin;
    $past(presetn) && $stable(high_speed_capture_port_on) |->
      shared_pin_out == (high_speed_capture_port_on ? $past(capture_port_clock) : $past(third_pulse_output));
  endproperty
  a_pin: assert property (p_pin) else $error("Shared pin source wrong.");
  property p_va;
    rd_cfg |=> volt_for_current_a == pick($past(prdata[9:8]), $past(voltage_a), $past(voltage_b), $past(voltage_c));
  endproperty
  a_va: assert property (p_va) else $error("Phase A pairing wrong.");
  property p_vb;
    rd_cfg |=> volt_for_current_b == pick($past(prdata[11:10]), $past(voltage_b), $past(voltage_c), $past(voltage_a));
  endproperty
  a_vb: assert property (p_vb) else $error("Phase B pairing wrong.");
  property p_vc;
    rd_cfg |=> volt_for_current_c == pick($past(prdata[13:12]), $past(voltage_c), $past(voltage_a), $past(voltage_b));
  endproperty
  a_vc: assert property (p_vc) else $error("Phase C pairing wrong.");
  property p_nrm;
    rd_cfg |=> neutral_rms_result == ($past(prdata[14]) ? $past(phase_current_sum_rms) : $past(neutral_current_rms));
  endproperty
  a_nrm: assert property (p_nrm) else $error("Neutral result source wrong.");
  property p_swr;
    s_swr |=> soft_reset_active [*8];
  endproperty
  a_swr: assert property (p_swr) else $error("Soft reset did not start.");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mcu_consts.vh"
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0, r, d, prdata, neutral_rms_result, filter_settle_cycles;
  logic        pready, pslverr, shared_pin_out, high_speed_capture_port_on, filter_settling, soft_reset_active;
  logic        third_pulse_output = 0, capture_port_clock = 0;
  logic [23:0] voltage_a = 24'h1, voltage_b = 24'h2, voltage_c = 24'h3;
  logic [23:0] volt_for_current_a, volt_for_current_b, volt_for_current_c;
  logic [31:0] neutral_current_rms = 32'hA5, phase_current_sum_rms = 32'h5A;
  int          fails = 0, compares = 0, cyc = 0, i, n;
  // Short settling counts keep the run brief.
  mcu_config_upper #(.LPF_SHORT_CYC(20), .LPF_LONG_CYC(40)) dut (.*);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    capture_port_clock <= ~capture_port_clock;
    third_pulse_output <= capture_port_clock;
    if (cyc == 4000)
    begin
      fails++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [19:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] ev(int ph, int c);
    return 32'((c == 1 ? (ph + 1) % 3 : (c == 2 ? (ph + 2) % 3 : ph)) + 1);
  endfunction
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, `MCU_CFG_ADDR, 0); chk(r, 0);
    apb(0, `MCU_NRMS_ADDR, 0); chk(r, neutral_current_rms);
    apb(0, 20'h00004, 0); chk({31'h0, er}, 1);
    for (i = 0; i < 4; i++)
    begin
      d = 32'h801F | (i << 8) | (i << 10) | (i << 12) | ((i % 2) << 14) | ((i % 2) << 6) | ((i / 2) << 5);
      apb(1, `MCU_CFG_ADDR, d);
      apb(0, `MCU_CFG_ADDR, 0); chk(r, d & 32'h7F60);
      chk(volt_for_current_a, ev(0, i));
      chk(volt_for_current_b, ev(1, i));
      chk(volt_for_current_c, ev(2, i));
      chk(high_speed_capture_port_on, i % 2);
      chk(filter_settle_cycles, (i / 2) ? 40 : 20);
      apb(0, `MCU_NRMS_ADDR, 0); chk(r, (i % 2) ? phase_current_sum_rms : neutral_current_rms);
    end
    apb(1, `MCU_CFG_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    n = 0;
    while (filter_settling === 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n, 20);
    apb(1, `MCU_CFG_ADDR, 32'h7FE0);
    apb(0, `MCU_CFG_ADDR, 0); chk(r[7], 1);
    n = 0;
    while (soft_reset_active === 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(soft_reset_active, 0);
    apb(0, `MCU_CFG_ADDR, 0); chk(r, 0);
    chk(volt_for_current_b, ev(1, 0));
    print_verdict();
  end
endmodule
bind mcu_config_upper mcu_config_upper_chk #(.DW(DW), .LPF_SHORT_CYC(LPF_SHORT_CYC),
  .LPF_LONG_CYC(LPF_LONG_CYC), .SWR_CYC(SWR_CYC)) chk_i (.*);
`default_nettype wire
